/* design/ptg_pkg.sv */
// shared constants and field layouts of the ten-bit pwm generator
package ptg_pkg;

  // register byte offsets
  localparam logic [7:0] PTG_OFF_TIMER  = 8'h00;
  localparam logic [7:0] PTG_OFF_LIMIT  = 8'h04;
  localparam logic [7:0] PTG_OFF_TCTRL  = 8'h08;
  localparam logic [7:0] PTG_OFF_DLOW   = 8'h0C;
  localparam logic [7:0] PTG_OFF_DBUF   = 8'h10;
  localparam logic [7:0] PTG_OFF_MCTRL  = 8'h14;
  localparam logic [7:0] PTG_OFF_PINDIR = 8'h18;

  // reset values
  localparam logic [7:0] PTG_RST_LIMIT  = 8'hFF;
  localparam logic [7:0] PTG_RST_ZERO   = 8'h00;
  localparam logic       PTG_RST_PINDIR = 1'b1;

  // mode select codes of the module control register
  localparam logic [3:0] PTG_MODE_OFF = 4'h0;
  localparam logic [3:0] PTG_MODE_PWM = 4'hC;

  // prescale select codes
  localparam logic [1:0] PTG_PS_DIV1 = 2'h0;
  localparam logic [1:0] PTG_PS_DIV4 = 2'h1;

  // last count of the divider: four clocks per step times the prescale factor
  localparam logic [5:0] PTG_DIV_LAST_1  = 6'h03;
  localparam logic [5:0] PTG_DIV_LAST_4  = 6'h0F;
  localparam logic [5:0] PTG_DIV_LAST_16 = 6'h3F;

  // axi responses
  localparam logic [1:0] PTG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PTG_RESP_SLVERR = 2'h2;

  // period timer control: bit 7 reads zero
  typedef struct packed {
    logic [3:0] postscale_select;
    logic       period_timer_on;
    logic [1:0] prescale_select;
  } ptg_tctrl_type;

  // module control: bits 7:6 read zero
  typedef struct packed {
    logic [1:0] duty_lsb_field;
    logic [3:0] mode;
  } ptg_mctrl_type;

endpackage

/* design/ptg_pwm_top.sv */
// ten-bit pwm generator with period timer and axi4-lite register slave
//
// Overview of operation
// RULE1 - timer equal to period limit clears on next increment, new period starts
// RULE2 - output set at period start unless duty value is zero
// RULE3 - duty low register copied into duty buffer at each period boundary; here only while pwm mode is selected
// RULE4 - postscale setting never changes pwm period or frequency
// RULE5 - duty is duty low byte above control bits five and four
// RULE6 - high time equals duty times clock period times prescale factor
// RULE7 - duty writes accepted anytime, effective only after current period ends
// RULE8 - duty buffer readable but ignores writes while pwm mode active
// RULE9 - buffer plus two-bit latch compared to timer with two sub bits clears output
// RULE10 - duty longer than period never clears output, output stays high
// RULE11 - prescaler divides by one, four or sixteen, scaling period and duty
// RULE12 - software writes limit, duty, pin direction, prescale and enable, then mode
// RULE13 - no automatic shutdown of the pwm output exists here
// RULE14 - zero in module control forces output latch low
// RULE15 - mode value 1100 selects active-high pwm mode
// RULE16 - period is limit plus one, times four clocks, times prescale factor
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ptg_pwm_top
  import ptg_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  // write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // write response channel
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // read address channel
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  // read data channel
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // pwm pin
  output var  logic        pwm_output_pin,
  output var  logic        pwm_output_pin_oe_n
);

  logic          aw_full_q;
  logic          w_full_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic          wlane_q;
  logic          awready_q;
  logic          wready_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          arready_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;
  logic [7:0]    period_timer_q;
  logic [7:0]    period_limit_q;
  ptg_tctrl_type tctrl_q;
  logic [7:0]    duty_low_basic_q;
  logic [7:0]    duty_buffer_basic_q;
  logic [1:0]    duty_latch_q;
  ptg_mctrl_type mctrl_q;
  logic          pin_direction_bit_q;
  logic [5:0]    div_q;
  logic          pwm_q;
  logic          do_write;
  logic          wr_en;
  logic          wr_map_ok;
  logic          rd_map_ok;
  logic [7:0]    rd_byte;
  logic [5:0]    div_last;
  logic [5:0]    div_mask;
  logic [1:0]    sub_bits;
  logic          phase_end;
  logic          tick;
  logic          boundary;
  logic          pwm_mode;
  logic [9:0]    ext_count;
  logic [9:0]    ext_next;
  logic [9:0]    duty_cmp;
  logic          clr_match;

  assign do_write = aw_full_q && w_full_q && !bvalid_q;
  assign wr_en    = do_write && wlane_q && wr_map_ok;

  // address decode
  always_comb begin
    wr_map_ok = 1'b0;
    case (awaddr_q)
      PTG_OFF_TIMER, PTG_OFF_LIMIT, PTG_OFF_TCTRL, PTG_OFF_DLOW,
      PTG_OFF_DBUF, PTG_OFF_MCTRL, PTG_OFF_PINDIR: wr_map_ok = 1'b1;
      default: wr_map_ok = 1'b0;
    endcase
  end

  always_comb begin
    rd_map_ok = 1'b1;
    case (araddr)
      PTG_OFF_TIMER:  rd_byte = period_timer_q;
      PTG_OFF_LIMIT:  rd_byte = period_limit_q;
      PTG_OFF_TCTRL:  rd_byte = {1'b0, tctrl_q};
      PTG_OFF_DLOW:   rd_byte = duty_low_basic_q;
      PTG_OFF_DBUF:   rd_byte = duty_buffer_basic_q;
      PTG_OFF_MCTRL:  rd_byte = {2'b00, mctrl_q};
      PTG_OFF_PINDIR: rd_byte = {7'h00, pin_direction_bit_q};
      default: begin
        rd_byte   = 8'h00;
        rd_map_ok = 1'b0;
      end
    endcase
  end

  // write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wlane_q   <= 1'b0;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= PTG_RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        w_full_q <= 1'b1;
        wdata_q  <= wdata;
        wlane_q  <= wstrb[0];
        wready_q <= 1'b0;
      end
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_map_ok ? PTG_RESP_OKAY : PTG_RESP_SLVERR;
      end
      // reopen only after the response, so one write at a time
      if (bvalid_q && bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= PTG_RESP_OKAY;
    end else begin
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h00_0000, rd_byte};
        rresp_q   <= rd_map_ok ? PTG_RESP_OKAY : PTG_RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_limit_q      <= PTG_RST_LIMIT;
      tctrl_q             <= PTG_RST_ZERO[6:0];
      duty_low_basic_q    <= PTG_RST_ZERO;
      mctrl_q             <= PTG_RST_ZERO[5:0];
      pin_direction_bit_q <= PTG_RST_PINDIR;
    end else if (wr_en) begin
      case (awaddr_q)
        PTG_OFF_LIMIT:  period_limit_q <= wdata_q[7:0];
        PTG_OFF_TCTRL:  tctrl_q <= wdata_q[6:0];
        // RULE7 duty always writable
        PTG_OFF_DLOW:   duty_low_basic_q <= wdata_q[7:0];
        PTG_OFF_MCTRL:  mctrl_q <= wdata_q[5:0];
        PTG_OFF_PINDIR: pin_direction_bit_q <= wdata_q[0];
        default: ;
      endcase
    end
  end

  // prescaler: step phase and sub bits
  always_comb begin
    case (tctrl_q.prescale_select)
      PTG_PS_DIV1: begin
        div_last = PTG_DIV_LAST_1;
        div_mask = 6'h00;
        sub_bits = div_q[1:0];
      end
      PTG_PS_DIV4: begin
        div_last = PTG_DIV_LAST_4;
        div_mask = 6'h03;
        sub_bits = div_q[3:2];
      end
      default: begin
        div_last = PTG_DIV_LAST_16;
        div_mask = 6'h0F;
        sub_bits = div_q[5:4];
      end
    endcase
  end

  // RULE4 postscale never enters the period path
  assign phase_end = (div_q & div_mask) == div_mask;
  assign tick      = tctrl_q.period_timer_on && (div_q == div_last);
  assign boundary  = tick && (period_timer_q == period_limit_q);
  // RULE15 only 1100 runs the pwm
  assign pwm_mode  = mctrl_q.mode == PTG_MODE_PWM;
  // RULE9 timer extended by two sub bits
  assign ext_count = {period_timer_q, sub_bits};
  assign ext_next  = ext_count + 10'h001;
  assign duty_cmp  = {duty_buffer_basic_q, duty_latch_q};
  // clear lands on the edge where the extended count reaches the duty
  assign clr_match = tctrl_q.period_timer_on && phase_end && (ext_next == duty_cmp);

  // RULE11 divide by one, four or sixteen, times four clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 6'h00;
    end else if (wr_en && (awaddr_q == PTG_OFF_TIMER || awaddr_q == PTG_OFF_TCTRL)) begin
      div_q <= 6'h00;
    end else if (tctrl_q.period_timer_on) begin
      div_q <= (div_q == div_last) ? 6'h00 : div_q + 6'h01;
    end
  end

  // RULE1 RULE16 timer wraps after limit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_timer_q <= PTG_RST_ZERO;
    end else if (wr_en && awaddr_q == PTG_OFF_TIMER) begin
      period_timer_q <= wdata_q[7:0];
    end else if (boundary) begin
      period_timer_q <= 8'h00;
    end else if (tick) begin
      period_timer_q <= period_timer_q + 8'h01;
    end
  end

  // RULE3 RULE5 double buffer of the ten-bit duty
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_buffer_basic_q <= PTG_RST_ZERO;
      duty_latch_q        <= 2'b00;
    end else if (pwm_mode && boundary) begin
      duty_buffer_basic_q <= duty_low_basic_q;
      duty_latch_q        <= mctrl_q.duty_lsb_field;
    // RULE8 buffer write only outside pwm
    end else if (!pwm_mode && wr_en && awaddr_q == PTG_OFF_DBUF) begin
      duty_buffer_basic_q <= wdata_q[7:0];
    end
  end

  // RULE13 no shutdown input: only mode and duty steer the output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_q <= 1'b0;
    // RULE14 leaving pwm mode drives latch low
    end else if (!pwm_mode) begin
      pwm_q <= 1'b0;
    // RULE2 set at period start, zero duty stays low
    end else if (boundary) begin
      pwm_q <= {duty_low_basic_q, mctrl_q.duty_lsb_field} != 10'h000;
    // RULE6 RULE9 RULE10 clear at duty match only
    end else if (clr_match) begin
      pwm_q <= 1'b0;
    end
  end

  assign awready             = awready_q;
  assign wready              = wready_q;
  assign bvalid              = bvalid_q;
  assign bresp               = bresp_q;
  assign arready             = arready_q;
  assign rvalid              = rvalid_q;
  assign rdata               = rdata_q;
  assign rresp               = rresp_q;
  assign pwm_output_pin      = pwm_q;
  assign pwm_output_pin_oe_n = pin_direction_bit_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_timer_wrap;
    boundary && !wr_en |=> period_timer_q == 8'h00;
  endproperty
  a_timer_wrap: assert property (p_timer_wrap) else $error("timer did not wrap"); // RULE1

  property p_period_set;
    pwm_mode && boundary && {duty_low_basic_q, mctrl_q.duty_lsb_field} != 10'h000
      ##1 pwm_mode |-> pwm_q;
  endproperty
  a_period_set: assert property (p_period_set) else $error("output not set at start"); // RULE2

  property p_zero_low;
    pwm_mode && boundary && {duty_low_basic_q, mctrl_q.duty_lsb_field} == 10'h000
      |=> !pwm_q;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero duty drove high"); // RULE2

  property p_latch;
    pwm_mode && boundary |=> duty_buffer_basic_q == $past(duty_low_basic_q)
      && duty_latch_q == $past(mctrl_q.duty_lsb_field);
  endproperty
  a_latch: assert property (p_latch) else $error("duty not latched"); // RULE3

  property p_hold_buffer;
    pwm_mode && !boundary |=> $stable(duty_buffer_basic_q) && $stable(duty_latch_q);
  endproperty
  a_hold_buffer: assert property (p_hold_buffer) else $error("buffer moved mid period"); // RULE8

  property p_clear_match;
    pwm_mode && !boundary && clr_match ##1 pwm_mode |-> !pwm_q;
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("no clear on match"); // RULE9

  property p_long_duty;
    pwm_mode && pwm_q && !boundary && duty_cmp > {period_limit_q, 2'b11}
      && !wr_en ##1 pwm_mode |-> pwm_q;
  endproperty
  a_long_duty: assert property (p_long_duty) else $error("long duty cleared"); // RULE10

  property p_off_low;
    mctrl_q.mode == PTG_MODE_OFF |=> !pwm_q;
  endproperty
  a_off_low: assert property (p_off_low) else $error("output high while off"); // RULE14

  // divider walks 0 up to its last count, then restarts
  property p_step_rate;
    tctrl_q.period_timer_on && !wr_en |=>
      div_q == (($past(div_q) == ((tctrl_q.prescale_select == PTG_PS_DIV1) ? PTG_DIV_LAST_1 :
                                  (tctrl_q.prescale_select == PTG_PS_DIV4) ? PTG_DIV_LAST_4 :
                                  PTG_DIV_LAST_16)) ? 6'h00 : $past(div_q) + 6'h01);
  endproperty
  a_step_rate: assert property (p_step_rate) else $error("wrong step rate"); // RULE11

  property p_bresp_hold;
    bvalid_q && !bready |=> bvalid_q && $stable(bresp_q);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  c_period: cover property (pwm_mode && boundary && duty_cmp != 10'h000);
  c_clear: cover property (pwm_mode && pwm_q ##1 !pwm_q);
  c_write: cover property (bvalid_q && bready);
  c_read: cover property (rvalid_q && rready);
  c_long: cover property (pwm_mode && pwm_q && duty_cmp > {period_limit_q, 2'b11});

endmodule
`default_nettype wire

/* tb/ptg_pwm_top_tb_top.sv */
// self-checking testbench of the ten-bit pwm generator
`timescale 1ns/100ps
`default_nettype none
module ptg_pwm_top_tb_top
  import ptg_pkg::*;
;
  // generous ceiling: slowest test runs a few hundred clocks
  localparam int TIMEOUT_CYCLES = 20000;

  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        pwm_output_pin;
  logic        pwm_output_pin_oe_n;
  int          n_mismatch;
  int          cmp_count;
  int          cyc = 0;

  ptg_pwm_top uut (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .awaddr              (awaddr),
    .awvalid             (awvalid),
    .awready             (awready),
    .wdata               (wdata),
    .wstrb               (wstrb),
    .wvalid              (wvalid),
    .wready              (wready),
    .bresp               (bresp),
    .bvalid              (bvalid),
    .bready              (bready),
    .araddr              (araddr),
    .arvalid             (arvalid),
    .arready             (arready),
    .rdata               (rdata),
    .rresp               (rresp),
    .rvalid              (rvalid),
    .rready              (rready),
    .pwm_output_pin      (pwm_output_pin),
    .pwm_output_pin_oe_n (pwm_output_pin_oe_n)
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // a hang anywhere ends here rather than stalling the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYCLES) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // address and data offered together, each released once taken
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
    logic aw_on;
    logic w_on;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_on = 1'b1;
    w_on = 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_on && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_on = 1'b0;
      end
      if (bvalid === 1'b1) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [7:0] d, output logic [1:0] resp);
    logic ar_on;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_on = 1'b1;
    forever begin
      @(posedge aclk);
      if (ar_on && arready === 1'b1) begin
        arvalid <= 1'b0;
        ar_on = 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata[7:0];
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check({30'h0, r}, {30'h0, PTG_RESP_OKAY});
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check({22'h0, r, d}, {22'h0, PTG_RESP_OKAY, exp});
  endtask

  // high time and full period of one pwm cycle, sampled at falling edges
  task automatic measure(output int hi, output int per);
    hi = 0;
    @(negedge aclk);
    while (pwm_output_pin !== 1'b0) @(negedge aclk);
    while (pwm_output_pin !== 1'b1) @(negedge aclk);
    while (pwm_output_pin === 1'b1) begin
      hi = hi + 1;
      @(negedge aclk);
    end
    per = hi;
    while (pwm_output_pin === 1'b0) begin
      per = per + 1;
      @(negedge aclk);
    end
  endtask

  task automatic pin_holds(input logic lvl);
    logic bad;
    bad = 1'b0;
    repeat (40) begin
      @(negedge aclk);
      if (pwm_output_pin !== lvl) bad = 1'b1;
    end
    check({31'h0, bad}, 32'h0);
  endtask

  task automatic test_reset_and_map();
    logic [7:0] d;
    logic [1:0] r;
    check({30'h0, pwm_output_pin_oe_n, pwm_output_pin}, 32'h2);
    rd_check(PTG_OFF_LIMIT, PTG_RST_LIMIT);
    rd_check(PTG_OFF_TIMER, PTG_RST_ZERO);
    rd_check(PTG_OFF_MCTRL, PTG_RST_ZERO);
    axi_read(8'h40, d, r);
    check({22'h0, r, d}, {22'h0, PTG_RESP_SLVERR, 8'h00});
    axi_write(8'h40, 8'h5A, r);
    check({30'h0, r}, {30'h0, PTG_RESP_SLVERR});
    $display("test reset and map done");
  endtask

  task automatic test_basic_wave();
    int hi;
    int per;
    // setup order: limit, duty, pin, timer, mode
    wr(PTG_OFF_LIMIT, 8'h00);
    wr(PTG_OFF_DLOW, 8'h00);
    wr(PTG_OFF_MCTRL, 8'h20);
    wr(PTG_OFF_PINDIR, 8'h00);
    wr(PTG_OFF_TCTRL, 8'h04);
    wr(PTG_OFF_MCTRL, 8'h2C);
    measure(hi, per);
    check(hi, 32'd2);
    check(per, 32'd4);
    check({31'h0, pwm_output_pin_oe_n}, 32'h0);
    $display("test basic wave done");
  endtask

  task automatic test_prescale();
    int hi;
    int per;
    int p;
    wr(PTG_OFF_LIMIT, 8'h01);
    wr(PTG_OFF_DLOW, 8'h01);
    wr(PTG_OFF_MCTRL, 8'h1C);
    // postscale held at its maximum to show it leaves the period alone
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 1 : ((i == 1) ? 4 : 16);
      wr(PTG_OFF_TCTRL, 8'h7C | i[7:0]);
      measure(hi, per);
      check(hi, 5 * p);
      check(per, 8 * p);
    end
    $display("test prescale done");
  endtask

  task automatic test_buffer_and_edges();
    // timer stopped so no boundary can latch the new duty early
    wr(PTG_OFF_TCTRL, 8'h00);
    wr(PTG_OFF_DLOW, 8'h03);
    wr(PTG_OFF_DBUF, 8'hAA);
    rd_check(PTG_OFF_DBUF, 8'h01);
    wr(PTG_OFF_TCTRL, 8'h04);
    repeat (20) @(posedge aclk);
    rd_check(PTG_OFF_DBUF, 8'h03);
    // duty 13 exceeds the 8-clock period
    pin_holds(1'b1);
    wr(PTG_OFF_MCTRL, 8'h00);
    pin_holds(1'b0);
    wr(PTG_OFF_DBUF, 8'h5A);
    rd_check(PTG_OFF_DBUF, 8'h5A);
    // other mode codes and zero duty in pwm mode keep pin low
    wr(PTG_OFF_MCTRL, 8'h0D);
    pin_holds(1'b0);
    wr(PTG_OFF_DLOW, 8'h00);
    wr(PTG_OFF_MCTRL, 8'h0C);
    pin_holds(1'b0);
    $display("test buffer and edges done");
  endtask

  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    test_reset_and_map();
    test_basic_wave();
    test_prescale();
    test_buffer_and_edges();
    tally_and_finish();
  end
endmodule
`default_nettype wire
